// [asp_map.vh]
// Constants for the asynchronous SRAM port host controller
`ifndef ASP_MAP_VH
`define ASP_MAP_VH
`define ASP_ADDR_W 19
`define ASP_DATA_W 8
`define ASP_CLK_NS 10
// Pin timing in ns (speed grade 55)
`define ASP_T_CYCLE_NS 55
`define ASP_T_WLWH_NS 45
`define ASP_T_WLQZ_NS 20
`define ASP_T_DVWH_NS 25
// Cycle counts, least times rounded up
`define ASP_RD_CYC ((`ASP_T_CYCLE_NS + `ASP_CLK_NS - 1) / `ASP_CLK_NS)
`define ASP_WR_CYC ((`ASP_T_WLWH_NS + `ASP_CLK_NS - 1) / `ASP_CLK_NS)
`define ASP_REL_CYC ((`ASP_T_WLQZ_NS + `ASP_CLK_NS - 1) / `ASP_CLK_NS)
`define ASP_DV_CYC ((`ASP_T_DVWH_NS + `ASP_CLK_NS - 1) / `ASP_CLK_NS)
`define ASP_CNT_W 4
`define ASP_ST_IDLE 2'h0
`define ASP_ST_READ 2'h1
`define ASP_ST_WRITE 2'h2
`define ASP_ST_RECOV 2'h3
`endif

// [asp_host.v]
// Host controller that drives a 512K x 8 asynchronous SRAM over its pins
// Operation
// - Keep cs_n or stor_n high while address changes between writes.
// - Write starts when cs_n and stor_n both low; setup from later edge.
// - Write ends at first rising edge; data valid before, held after.
// - Host drives data only after device releases bus following stor_n fall; code drives it one cycle after the fall.
`include "asp_map.vh"
`default_nettype none
module asp_host #(
  parameter ADDR_W = `ASP_ADDR_W,
  parameter DATA_W = `ASP_DATA_W
) (
  input wire core_clk_i,
  input wire rstn_i,
  input wire req_i,
  input wire req_write_i,
  input wire [ADDR_W-1:0] req_addr_i,
  input wire [DATA_W-1:0] req_wdata_i,
  output reg req_ready_o,
  output reg rsp_valid_o,
  output reg [DATA_W-1:0] rsp_rdata_o,
  output reg [ADDR_W-1:0] addr_o,
  output reg cs_n_o,
  output reg out_drv_n_o,
  output reg stor_n_o,
  input wire [DATA_W-1:0] data_i,
  output reg [DATA_W-1:0] data_o,
  output reg data_oe_n_o
);
  // ----------------------------------------
  // Constants
  // ----------------------------------------
  localparam [1:0] ST_IDLE = `ASP_ST_IDLE;
  localparam [1:0] ST_READ = `ASP_ST_READ;
  localparam [1:0] ST_WRITE = `ASP_ST_WRITE;
  localparam [1:0] ST_RECOV = `ASP_ST_RECOV;
  localparam integer RD_CYC = `ASP_RD_CYC;
  localparam integer WR_CYC = `ASP_WR_CYC;
  localparam integer REL_CYC = `ASP_REL_CYC;
  // Loads cut to the counter width on purpose; all fit in four bits
  localparam [`ASP_CNT_W-1:0] RD_LOAD = RD_CYC[`ASP_CNT_W-1:0];
  localparam [`ASP_CNT_W-1:0] WR_LOAD = WR_CYC[`ASP_CNT_W-1:0];
  localparam [`ASP_CNT_W-1:0] REL_LOAD = REL_CYC[`ASP_CNT_W-1:0];
  localparam [`ASP_CNT_W-1:0] CNT_ZERO = {`ASP_CNT_W{1'b0}};
  localparam [`ASP_CNT_W-1:0] CNT_ONE = {{(`ASP_CNT_W-1){1'b0}}, 1'b1};

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [1:0] state;
  reg [`ASP_CNT_W-1:0] cnt;
  reg wr_phase;
  reg [1:0] next_state;
  reg [`ASP_CNT_W-1:0] next_cnt;
  reg next_wr_phase;
  reg next_req_ready;
  reg next_rsp_valid;
  reg [DATA_W-1:0] next_rsp_rdata;
  reg [ADDR_W-1:0] next_addr;
  reg next_cs_n;
  reg next_out_drv_n;
  reg next_stor_n;
  reg [DATA_W-1:0] next_data;
  reg next_data_oe_n;

  // ----------------------------------------
  // Counter helpers
  // ----------------------------------------
  function cnt_done;
    input [`ASP_CNT_W-1:0] c;
    begin
      cnt_done = (c == CNT_ZERO);
    end
  endfunction

  function [`ASP_CNT_W-1:0] cnt_dec;
    input [`ASP_CNT_W-1:0] c;
    begin
      cnt_dec = c - CNT_ONE;
    end
  endfunction

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always @*
  begin
    next_state = state;
    next_cnt = cnt;
    next_wr_phase = wr_phase;
    next_req_ready = req_ready_o;
    next_rsp_valid = 1'b0;
    next_rsp_rdata = rsp_rdata_o;
    next_addr = addr_o;
    next_cs_n = cs_n_o;
    next_out_drv_n = out_drv_n_o;
    next_stor_n = stor_n_o;
    next_data = data_o;
    next_data_oe_n = data_oe_n_o;
    case (state)
      ST_IDLE:
      begin
        next_req_ready = 1'b1;
        if (req_i && req_ready_o)
        begin
          next_req_ready = 1'b0;
          // Address settles while stor_n is still high
          next_addr = req_addr_i;
          next_cs_n = 1'b0;
          if (req_write_i)
          begin
            // Output enable stays off so the device never drives
            next_out_drv_n = 1'b1;
            next_data = req_wdata_i;
            next_state = ST_WRITE;
            next_wr_phase = 1'b0;
            next_cnt = REL_LOAD;
          end
          else
          begin
            next_out_drv_n = 1'b0;
            next_state = ST_READ;
            next_cnt = RD_LOAD;
          end
        end
      end
      ST_READ:
      begin
        if (cnt_done(cnt))
        begin
          // Sampled after full access delay from all three edges
          next_rsp_rdata = data_i;
          next_rsp_valid = 1'b1;
          next_cs_n = 1'b1;
          next_out_drv_n = 1'b1;
          next_state = ST_RECOV;
          next_cnt = CNT_ZERO;
        end
        else
          next_cnt = cnt_dec(cnt);
      end
      ST_WRITE:
      begin
        if (!wr_phase)
        begin
          if (cnt_done(cnt))
          begin
            // Later falling edge starts the write
            next_stor_n = 1'b0;
            next_wr_phase = 1'b1;
            next_cnt = WR_LOAD;
          end
          else
            next_cnt = cnt_dec(cnt);
        end
        else
        begin
          // Bus driven one cycle after stor_n falls; the REL_LOAD wait runs before the fall
          next_data_oe_n = 1'b0;
          if (cnt_done(cnt))
          begin
            // stor_n rises first and ends the write
            next_stor_n = 1'b1;
            next_state = ST_RECOV;
            next_cnt = CNT_ZERO;
          end
          else
            next_cnt = cnt_dec(cnt);
        end
      end
      ST_RECOV:
      begin
        // Data held one cycle past stor_n rise, then bus released
        next_data_oe_n = 1'b1;
        next_cs_n = 1'b1;
        next_wr_phase = 1'b0;
        next_state = ST_IDLE;
      end
      default:
        next_state = ST_IDLE;
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Every pin comes straight from a flop so no glitch reaches the memory
  always @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state <= ST_IDLE;
      cnt <= CNT_ZERO;
      wr_phase <= 1'b0;
      req_ready_o <= 1'b0;
      rsp_valid_o <= 1'b0;
      rsp_rdata_o <= {DATA_W{1'b0}};
      addr_o <= {ADDR_W{1'b0}};
      cs_n_o <= 1'b1;
      stor_n_o <= 1'b1;
      out_drv_n_o <= 1'b1;
      data_o <= {DATA_W{1'b0}};
      data_oe_n_o <= 1'b1;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      wr_phase <= next_wr_phase;
      req_ready_o <= next_req_ready;
      rsp_valid_o <= next_rsp_valid;
      rsp_rdata_o <= next_rsp_rdata;
      addr_o <= next_addr;
      cs_n_o <= next_cs_n;
      stor_n_o <= next_stor_n;
      out_drv_n_o <= next_out_drv_n;
      data_o <= next_data;
      data_oe_n_o <= next_data_oe_n;
    end
  end
endmodule // asp_host
`default_nettype wire

// [asp_host_monitor.sv]
// Pin order checker for the SRAM host port
`default_nettype none
module asp_host_monitor (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic req_i,
  input wire logic req_ready_o,
  input wire logic [18:0] addr_o,
  input wire logic cs_n_o,
  input wire logic out_drv_n_o,
  input wire logic stor_n_o,
  input wire logic [7:0] data_o,
  input wire logic data_oe_n_o
);
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);
  addr_hold_a: assert property ($changed(addr_o) |-> stor_n_o && $past(stor_n_o)) else $error("addr moved");
  wr_start_a: assert property ($fell(stor_n_o) |-> !cs_n_o && !$past(cs_n_o, 3)) else $error("early strobe");
  wr_data_a: assert property ($rose(stor_n_o) |-> !cs_n_o && !data_oe_n_o && !$past(data_oe_n_o, 3)
    && $stable(data_o)) else $error("data short");
  no_clash_a: assert property ($fell(data_oe_n_o) |-> out_drv_n_o && !stor_n_o && !$past(stor_n_o))
    else $error("bus clash");
  idle_safe_a: assert property ($fell(cs_n_o) |-> $past(req_i) && $past(req_ready_o)) else $error("stray select");
endmodule // asp_host_monitor
bind asp_host asp_host_monitor asp_host_monitor_i (.core_clk_i, .rstn_i, .req_i, .req_ready_o, .addr_o, .cs_n_o,
  .out_drv_n_o, .stor_n_o, .data_o, .data_oe_n_o);
`default_nettype wire

// [asp_sram.sv]
// Behavioural 512K x 8 asynchronous SRAM
`default_nettype none
module asp_sram (
  input wire logic [18:0] addr_i,
  input wire logic cs_n_i,
  input wire logic out_drv_n_i,
  input wire logic stor_n_i,
  input wire logic [7:0] data_i,
  input wire logic oe_n_i,
  output logic [7:0] bus_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [logic [18:0]];
  logic [7:0] q;
  // Undriven bus stores garbage so a late host drive shows up
  always @(posedge cs_n_i or posedge stor_n_i)
    if (!cs_n_i || !stor_n_i)
      mem[addr_i] = oe_n_i ? ~data_i : data_i;
  always @*
  begin
    q = mem.exists(addr_i) ? mem[addr_i] : 8'h00;
    if (!oe_n_i)
      bus_o = data_i;
    else if (!cs_n_i && stor_n_i && !out_drv_n_i)
      bus_o = q;
    else
      bus_o = ~q;
  end
endmodule // asp_sram
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the SRAM host port
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rstn = 0, req = 0, wr = 0, rdy, vld, cs_n, oe_n, st_n, doe_n;
  logic [18:0] a = 0, addr;
  logic [7:0] d = 0, q, dout, bus;
  logic [7:0] shadow [logic [18:0]];
  logic [31:0] lf = 32'h74B3;
  int num_errors = 0, n_checks = 0;
  initial forever #5 clk = ~clk;
  asp_host asp_host_i (.core_clk_i(clk), .rstn_i(rstn), .req_i(req), .req_write_i(wr), .req_addr_i(a),
    .req_wdata_i(d), .req_ready_o(rdy), .rsp_valid_o(vld), .rsp_rdata_o(q), .addr_o(addr), .cs_n_o(cs_n),
    .out_drv_n_o(oe_n), .stor_n_o(st_n), .data_i(bus), .data_o(dout), .data_oe_n_o(doe_n));
  asp_sram asp_sram_i (.addr_i(addr), .cs_n_i(cs_n), .out_drv_n_i(oe_n), .stor_n_i(st_n), .data_i(dout),
    .oe_n_i(doe_n), .bus_o(bus));
  function automatic logic [31:0] nxt(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task print_verdict;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(logic ok);
    n_checks++;
    if (!ok)
    begin
      num_errors++;
      $display("ERROR %0t mismatch", $time);
    end
  endtask
  // Always lets one edge pass first, so a just-dropped ready is not seen as still high
  task automatic wt(ref logic s);
    bit seen;
    seen = 0;
    for (int i = 0; i < 40 && !seen; i++)
    begin
      @(posedge clk);
      seen = (s === 1'b1);
    end
    if (!seen)
    begin
      chk(0);
      print_verdict;
    end
  endtask
  // Read data is judged against the bench's own copy of every write
  task op(logic w, logic [18:0] ad, logic [7:0] da);
    wt(rdy);
    req <= 1;
    wr <= w;
    a <= ad;
    d <= da;
    @(posedge clk);
    req <= 0;
    if (w) shadow[ad] = da;
    else
    begin
      wt(vld);
      chk(q === shadow[ad]);
    end
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    rstn <= 1;
    repeat (3) @(posedge clk);
    chk(cs_n === 1'b1 && st_n === 1'b1);
    op(1, 19'h00000, 8'h5A);
    op(1, 19'h7FFFF, 8'hA5);
    op(0, 19'h7FFFF, 8'h00);
    op(0, 19'h00000, 8'h00);
    $display("corner test done");
    for (int i = 0; i < 30; i++)
    begin
      lf = nxt(lf);
      op(1, lf[18:0], lf[26:19]);
      op(1, lf[18:0] ^ 19'h00001, ~lf[26:19]);
      op(0, lf[18:0], 8'h00);
    end
    $display("random test done");
    print_verdict;
  end
endmodule // tb_top
`default_nettype wire
